/* File: fpb_pkg.sv */
// fpb_pkg: port addresses, bit positions, reset values and window encodings
// for the flash page and boot flip control block.
// assumes: 16-bit I/O addresses, 8-bit I/O data, byte-wide 1 Mbyte flash array.
package fpb_pkg;

  localparam logic [15:0] FPB_PAGE_PORT  = 16'h1096;
  localparam logic [15:0] FPB_CTL_PORT   = 16'h2096;

  localparam int unsigned FPB_BIT_SEL    = 7;
  localparam int unsigned FPB_BIT_SW     = 6;
  localparam int unsigned FPB_BIT_JMP    = 5;
  localparam int unsigned FPB_BIT_EN     = 2;
  localparam int unsigned FPB_BIT_WIN_HI = 1;
  localparam int unsigned FPB_BIT_WIN_LO = 0;

  localparam logic [7:0]  FPB_PAGE_RST   = 8'h00;
  localparam logic        FPB_SEL_RST    = 1'b0;
  localparam logic        FPB_SW_RST     = 1'b0;
  localparam logic        FPB_EN_RST     = 1'b0;

  localparam int unsigned FPB_FLASH_AW   = 20;
  localparam int unsigned FPB_OFF_AW     = 16;

  typedef enum logic [1:0] {
    FPB_WIN_64K = 2'b00,
    FPB_WIN_32K = 2'b01,
    FPB_WIN_16K = 2'b10,
    FPB_WIN_8K  = 2'b11
  } fpb_win_t;

  localparam fpb_win_t    FPB_WIN_RST    = FPB_WIN_64K;

  // page bits sit directly above the in-window offset
  function automatic logic [FPB_FLASH_AW-1:0] fpb_flash_addr(
    input logic [7:0]            page,
    input fpb_win_t              win,
    input logic [FPB_OFF_AW-1:0] off
  );
    logic [FPB_FLASH_AW-1:0] a;
    a = '0;
    unique case (win)
      FPB_WIN_64K: a = {page[3:0], off[15:0]};
      FPB_WIN_32K: a = {page[4:0], off[14:0]};
      FPB_WIN_16K: a = {page[5:0], off[13:0]};
      FPB_WIN_8K:  a = {page[6:0], off[12:0]};
    endcase
    return a;
  endfunction

endpackage

/* File: fpb_win_if.sv */
// fpb_win_if: window settings passed from the register bank to the translator.
// assumes: both ends on the same clock.
`timescale 1ns/100ps
interface fpb_win_if;
  import fpb_pkg::*;
  logic [7:0] page;
  fpb_win_t   win_size;
  logic       enable;
  modport regs (output page, output win_size, output enable);
  modport xlat (input page, input win_size, input enable);
endinterface

/* File: fpb_win_xlat.sv */
// fpb_win_xlat: turns a window offset and the page settings into a flash address.
// assumes: mem_sel comes from the chipset range comparator, already decoded.
`timescale 1ns/100ps
module fpb_win_xlat
  import fpb_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  fpb_win_if.xlat                      win,
  input  wire logic                    mem_sel,
  input  wire logic [FPB_OFF_AW-1:0]   mem_offset,
  output logic      [FPB_FLASH_AW-1:0] flash_addr,
  output logic                         flash_ce
);

  logic [FPB_FLASH_AW-1:0] addr_q;
  logic                    ce_q;

  // address holds between accesses to keep flash lines quiet
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
    end else if (mem_sel) begin
      addr_q <= fpb_flash_addr(win.page, win.win_size, mem_offset); // [R1] [R2] [R3] [R4]
    end
  end

  // a disabled array never sees a chip enable, even inside the window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ce_q <= 1'b0;
    end else begin
      ce_q <= mem_sel & win.enable; // [R12] [R5]
    end
  end

  assign flash_addr = addr_q;
  assign flash_ce   = ce_q;

  a_ce_needs_enable: assert property (@(posedge clock) disable iff (rst) // [R12]
    flash_ce |-> ($past(win.enable) && $past(mem_sel)))
    else $error("flash enable without enable bit or window hit");

  a_addr_from_page: assert property (@(posedge clock) disable iff (rst) // [R2]
    mem_sel |=> flash_addr == fpb_flash_addr($past(win.page), $past(win.win_size),
                                             $past(mem_offset)))
    else $error("flash address does not follow page and window size");

  a_addr_holds: assert property (@(posedge clock) disable iff (rst) // [R3]
    !mem_sel |=> $stable(flash_addr))
    else $error("flash address moved outside a window access");

endmodule

/* File: fpb_flash_page_ctl.sv */
// fpb_flash_page_ctl: page register, page control and boot flip register,
// resident array window translation and boot flash half select.
// assumes: I/O strobes are one-cycle pulses synchronous to clock; jumper is static.
`timescale 1ns/100ps

// Summary of operation
// R1 - page register written at port 1096H
// R2 - page supplies upper flash address bits
// R3 - page size follows selected window size
// R4 - resident array is 1 Mbyte byte-wide
// R5 - chipset decodes window, presents hits only
// R6 - software places window in D0000-EFFFFH
// R7 - bit 7 picks jumper or software flip
// R8 - software flip bit 6, RW, zero at reset
// R9 - select set: software bit inverts half select
// R10 - bit 5 reads jumper, read only
// R11 - select zero after reset, jumper rules
// R12 - bit 2 enables array, resets disabled
// R13 - window code 00/01/10/11 = 64/32/16/8K
// R14 - window size resets to 64K
// R15 - control register decoded at port 2096H
// R16 - bits 4 and 3 read zero
// R17 - page register clears on reset
module fpb_flash_page_ctl
  import fpb_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [15:0]             io_addr,
  input  wire logic                    io_wr,
  input  wire logic                    io_rd,
  input  wire logic [7:0]              io_wdata,
  output logic      [7:0]              io_rdata,
  output logic                         io_rdata_valid,
  input  wire logic                    jumper_boot_flip,
  input  wire logic                    boot_addr_hi,
  output logic                         boot_flash_half_select,
  input  wire logic                    mem_sel,
  input  wire logic [FPB_OFF_AW-1:0]   mem_offset,
  output logic      [FPB_FLASH_AW-1:0] flash_addr,
  output logic                         flash_ce
);

  logic [7:0] flash_page_select_q;
  logic       flip_source_select_q;
  logic       software_boot_flip_q;
  logic       flash_array_enable_q;
  fpb_win_t   window_size_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       half_sel_q;
  logic       page_hit;
  logic       ctl_hit;
  logic [7:0] ctl_view;
  logic       flip_d;

  fpb_win_if win_bus ();

  assign page_hit = (io_addr == FPB_PAGE_PORT); // [R1]
  assign ctl_hit  = (io_addr == FPB_CTL_PORT);  // [R15]

  // page register; upper bits unused by small page counts still store
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_page_select_q <= FPB_PAGE_RST; // [R17]
    end else if (io_wr && page_hit) begin
      flash_page_select_q <= io_wdata; // [R1]
    end
  end

  // a write to any other port leaves the page alone
  a_page_store: assert property (@(posedge clock) disable iff (rst) // [R1]
    (io_wr && page_hit) |=> flash_page_select_q == $past(io_wdata))
    else $error("page write not stored");

  a_page_keep: assert property (@(posedge clock) disable iff (rst) // [R1]
    !(io_wr && page_hit) |=> $stable(flash_page_select_q))
    else $error("page register moved without a page write");

  // control register; bits 5, 4, 3 have no storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flip_source_select_q <= FPB_SEL_RST; // [R11]
      software_boot_flip_q <= FPB_SW_RST;  // [R8]
      flash_array_enable_q <= FPB_EN_RST;  // [R12]
      window_size_q        <= FPB_WIN_RST; // [R14]
    end else if (io_wr && ctl_hit) begin
      flip_source_select_q <= io_wdata[FPB_BIT_SEL]; // [R7]
      software_boot_flip_q <= io_wdata[FPB_BIT_SW];  // [R8]
      flash_array_enable_q <= io_wdata[FPB_BIT_EN];  // [R12]
      window_size_q        <= fpb_win_t'({io_wdata[FPB_BIT_WIN_HI],
                                          io_wdata[FPB_BIT_WIN_LO]}); // [R13]
    end
  end

  // flip bits must land together, or the half select steps twice
  a_flip_store: assert property (@(posedge clock) disable iff (rst) // [R7]
    (io_wr && ctl_hit) |=> flip_source_select_q == $past(io_wdata[FPB_BIT_SEL])
                          && software_boot_flip_q == $past(io_wdata[FPB_BIT_SW]))
    else $error("flip select or software flip not stored");

  a_ctl_keep: assert property (@(posedge clock) disable iff (rst) // [R8]
    !(io_wr && ctl_hit) |=> $stable(ctl_view[7:6]) && $stable(ctl_view[2:0]))
    else $error("control bits moved without a control write");

  always_comb begin
    ctl_view                 = 8'h00; // [R16]
    ctl_view[FPB_BIT_SEL]    = flip_source_select_q;
    ctl_view[FPB_BIT_SW]     = software_boot_flip_q;
    ctl_view[FPB_BIT_JMP]    = jumper_boot_flip; // [R10]
    ctl_view[FPB_BIT_EN]     = flash_array_enable_q;
    ctl_view[FPB_BIT_WIN_HI] = window_size_q[1];
    ctl_view[FPB_BIT_WIN_LO] = window_size_q[0];
  end

  // read data one cycle after the strobe; unmapped ports return zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= io_rd;
      if (io_rd) begin
        rdata_q <= page_hit ? flash_page_select_q : (ctl_hit ? ctl_view : 8'h00);
      end
    end
  end

  // every read answers in exactly one cycle, and nothing answers unasked
  a_read_answer: assert property (@(posedge clock) disable iff (rst) // [R15]
    io_rd |=> io_rdata_valid)
    else $error("read strobe got no answer");

  a_valid_pulse: assert property (@(posedge clock) disable iff (rst) // [R15]
    io_rdata_valid |-> $past(io_rd))
    else $error("read answer without a read strobe");

  a_rdata_hold: assert property (@(posedge clock) disable iff (rst) // [R1]
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");

  a_read_ctl_bits: assert property (@(posedge clock) disable iff (rst) // [R8]
    (io_rd && ctl_hit) |=> io_rdata[7:6] == $past({flip_source_select_q, software_boot_flip_q}))
    else $error("flip bits do not read back");

  // registered so the boot half select never glitches inside a cycle
  // jumper absent reads 1 and means inverted
  assign flip_d = flip_source_select_q ? software_boot_flip_q : jumper_boot_flip; // [R7] [R11]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_sel_q <= 1'b0;
    end else begin
      half_sel_q <= boot_addr_hi ^ flip_d; // [R9] [R10]
    end
  end

  // software flip has no effect until the select bit is set
  a_sw_masked: assert property (@(posedge clock) disable iff (rst) // [R11]
    (!flip_source_select_q && $stable(flip_source_select_q) && $changed(software_boot_flip_q)
     && $stable(boot_addr_hi) && $stable(jumper_boot_flip))
      |=> $stable(boot_flash_half_select))
    else $error("software flip leaked through while select is low");

  assign win_bus.page     = flash_page_select_q;
  assign win_bus.win_size = window_size_q;
  assign win_bus.enable   = flash_array_enable_q;

  // window placement in upper memory is the chipset's job
  fpb_win_xlat u_xlat (
    .clock      (clock),
    .rst        (rst),
    .win        (win_bus),
    .mem_sel    (mem_sel), // [R5] [R6]
    .mem_offset (mem_offset),
    .flash_addr (flash_addr),
    .flash_ce   (flash_ce)
  );

  // a disabled array keeps its chip enable low
  a_ce_disabled: assert property (@(posedge clock) disable iff (rst) // [R12]
    !flash_array_enable_q |=> !flash_ce)
    else $error("chip enable with array disabled");

  assign io_rdata               = rdata_q;
  assign io_rdata_valid         = rvalid_q;
  assign boot_flash_half_select = half_sel_q;

  a_page_write_read: assert property (@(posedge clock) disable iff (rst) // [R1]
    (io_wr && page_hit) ##1 (io_rd && page_hit && !io_wr)
      |=> io_rdata == $past(io_wdata, 2) && io_rdata_valid)
    else $error("page register read back differs from write");

  a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // [R16]
    (io_rd && ctl_hit) |=> io_rdata[4:3] == 2'b00)
    else $error("reserved control bits read nonzero");

  a_jumper_read: assert property (@(posedge clock) disable iff (rst) // [R10]
    (io_rd && ctl_hit) |=> io_rdata[FPB_BIT_JMP] == $past(jumper_boot_flip))
    else $error("jumper bit does not reflect the jumper");

  a_flip_jumper: assert property (@(posedge clock) disable iff (rst) // [R11]
    !flip_source_select_q |=> boot_flash_half_select ==
                              ($past(boot_addr_hi) ^ $past(jumper_boot_flip)))
    else $error("half select ignores jumper while select is low");

  a_flip_software: assert property (@(posedge clock) disable iff (rst) // [R9]
    flip_source_select_q |=> boot_flash_half_select ==
                             ($past(boot_addr_hi) ^ $past(software_boot_flip_q)))
    else $error("half select ignores software flip while select is high");

  a_ctl_write: assert property (@(posedge clock) disable iff (rst) // [R13]
    (io_wr && ctl_hit) |=> window_size_q == $past(io_wdata[1:0])
                          && flash_array_enable_q == $past(io_wdata[FPB_BIT_EN]))
    else $error("control write not stored");

  a_reset_state: assert property (@(posedge clock) // [R14]
    $fell(rst) |-> window_size_q == FPB_WIN_64K && !flip_source_select_q
                   && !software_boot_flip_q && !flash_array_enable_q
                   && flash_page_select_q == 8'h00)
    else $error("control state not at reset values");

  a_unmapped_zero: assert property (@(posedge clock) disable iff (rst) // [R15]
    (io_rd && !ctl_hit && !page_hit) |=> io_rdata == 8'h00 && io_rdata_valid)
    else $error("unmapped port read nonzero");

endmodule

/* File: fpb_isa_host.sv */
// fpb_isa_host: chipset side model, I/O register cycles and window hits.
// assumes: one clock; requests launched just after a rising edge.
`timescale 1ns/100ps
module fpb_isa_host
  import fpb_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic [7:0]            io_rdata,
  input  wire logic                  io_rdata_valid,
  output logic      [15:0]           io_addr,
  output logic                       io_wr,
  output logic                       io_rd,
  output logic      [7:0]            io_wdata,
  output logic                       mem_sel,
  output logic      [FPB_OFF_AW-1:0] mem_offset
);
  initial begin
    {io_addr, io_wr, io_rd, io_wdata, mem_sel, mem_offset} = '0;
  end
  // one byte write or read; ok low means no answer came
  task automatic io_cyc(input logic [15:0] a, input logic [7:0] d, input logic wr,
                        output logic [7:0] q, output logic ok);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= wr;
    io_rd <= !wr;
    @(posedge clock);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    // released address and data lines never keep their last value
    io_addr <= ~a;
    io_wdata <= ~d;
    ok = wr;
    q = '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = io_rdata_valid === 1'b1;
      q = io_rdata;
      if (!ok) begin
        @(posedge clock);
      end
    end
  endtask
  // write then read of one port on the very next edge, no gap
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clock);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    @(posedge clock);
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    ok = 1'b0;
    q = '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = io_rdata_valid === 1'b1;
      q = io_rdata;
      if (!ok) begin
        @(posedge clock);
      end
    end
  endtask
  task automatic win_cyc(input logic [15:0] off, input fpb_win_t w);
    @(posedge clock);
    mem_sel <= 1'b1;
    mem_offset <= off & (16'hffff >> w);
    @(posedge clock);
    mem_sel <= 1'b0;
    mem_offset <= ~(off & (16'hffff >> w));
  endtask
endmodule

/* File: tb_flash_page_boot_flip_control.sv */
// tb_flash_page_boot_flip_control: random register, window and flip checks.
// assumes: fpb_isa_host runs every chipset cycle.
`timescale 1ns/100ps
module tb_flash_page_boot_flip_control
  import fpb_pkg::*;
;
  logic        clock, rst, jmp, bhi, wr, rd, msel, vld, half, ce, ok;
  logic [15:0] addr, moff, off;
  logic [7:0]  wd, rdat, q, ctl, pg;
  logic [19:0] fa;
  int          failures, cmp_count, r;

  fpb_flash_page_ctl dut (.clock(clock), .rst(rst), .io_addr(addr), .io_wr(wr),
    .io_rd(rd), .io_wdata(wd), .io_rdata(rdat), .io_rdata_valid(vld),
    .jumper_boot_flip(jmp), .boot_addr_hi(bhi), .boot_flash_half_select(half),
    .mem_sel(msel), .mem_offset(moff), .flash_addr(fa), .flash_ce(ce));
  fpb_isa_host host (.clock(clock), .io_rdata(rdat), .io_rdata_valid(vld),
    .io_addr(addr), .io_wr(wr), .io_rd(rd), .io_wdata(wd), .mem_sel(msel),
    .mem_offset(moff));

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    host.io_cyc(a, 8'h00, 1'b0, q, ok);
    if (!ok) begin
      failures++;
      give_verdict();
    end else begin
      check(q, exp);
    end
  endtask
  task automatic wr_rd_chk(input logic [7:0] d);
    host.wr_rd(FPB_PAGE_PORT, d, q, ok);
    if (!ok) begin
      failures++;
      give_verdict();
    end else begin
      check(q, d);
    end
  endtask
  // page bits land just above the in-window offset
  function automatic logic [19:0] exp_addr(logic [7:0] p, logic [1:0] w, logic [15:0] o);
    return (20'(p) << (16 - w)) | (20'(o) & ((20'h1 << (16 - w)) - 20'h1));
  endfunction
  function automatic logic [7:0] exp_ctl(logic [7:0] c, logic j);
    return {c[7:6], j, 2'b00, c[2:0]};
  endfunction
  function automatic logic exp_half(logic [7:0] c, logic j, logic b);
    return b ^ (c[7] ? c[6] : j);
  endfunction

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    jmp = 1'b1;
    bhi = 1'b0;
    failures = 0;
    cmp_count = 0;
    r = $urandom(22856);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd_chk(FPB_PAGE_PORT, 8'h00);
    rd_chk(FPB_CTL_PORT, exp_ctl(8'h00, jmp));
    check(half, exp_half(8'h00, jmp, bhi));
    host.win_cyc(16'h1234, FPB_WIN_64K);
    #1;
    check(fa, exp_addr(8'h00, 2'b00, 16'h1234));
    check(ce, 1'b0);
    // near-miss ports must neither write nor answer with data
    host.io_cyc(16'h0096, 8'hff, 1'b1, q, ok);
    rd_chk(FPB_PAGE_PORT, 8'h00);
    rd_chk(16'h1097, 8'h00);
    for (int i = 0; i < 48; i++) begin
      pg = 8'($urandom);
      ctl = {6'($urandom), 2'(i)};
      off = 16'($urandom);
      @(posedge clock);
      jmp <= 1'($urandom);
      bhi <= 1'($urandom);
      host.io_cyc(FPB_PAGE_PORT, pg, 1'b1, q, ok);
      host.io_cyc(FPB_CTL_PORT, ctl, 1'b1, q, ok);
      rd_chk(FPB_PAGE_PORT, pg);
      rd_chk(FPB_CTL_PORT, exp_ctl(ctl, jmp));
      check(half, exp_half(ctl, jmp, bhi));
      host.win_cyc(off, fpb_win_t'(ctl[1:0]));
      #1;
      check(fa, exp_addr(pg, ctl[1:0], off));
      check(ce, ctl[2]);
      @(posedge clock);
      #1;
      check(ce, 1'b0);
      wr_rd_chk(~pg);
    end
    give_verdict();
  end
endmodule
